// >>> logic/sfhold_pkg.sv
// sfhold_pkg: constants and types shared by the hold / io3 control block
package sfhold_pkg;
	localparam int unsigned CMD_W = 8;
	localparam logic [7:0] CMD_PROG_QUAD = 8'h32;
	localparam logic [7:0] CMD_READ_QUAD = 8'h6b;
	localparam logic [7:0] CMD_READ_QUAD_IO = 8'heb;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] QUAD_NIBBLE = 4'h4;
	localparam logic [3:0] SINGLE_BIT = 4'h1;
	typedef enum logic [1:0] {SFH_IDLE, SFH_CMD, SFH_QIN, SFH_QOUT} sfhold_phase_t;
endpackage

// >>> logic/sfhold_xfer_if.sv
// sfhold_xfer_if: byte stream between link-side shifter and system side
`timescale 1ns/1ps
`default_nettype none
interface sfhold_xfer_if;
	logic rx_toggle;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;
	logic [7:0] cmd;
	logic held;
	modport link (output rx_toggle, output rx_byte, output cmd, output held, input tx_byte);
	modport sys (input rx_toggle, input rx_byte, input cmd, input held, output tx_byte);
endinterface
`default_nettype wire

// >>> logic/sfhold_link.sv
// sfhold_link: link-clock shifter with hold gating and io3 steering
`timescale 1ns/1ps
`default_nettype none
module sfhold_link (
	input wire logic sck_in,
	input wire logic cs_b_in,
	input wire logic hold_b_in,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_out,
	sfhold_xfer_if.link xf
);
	// ****************************************
	// input shifter (rising edge)
	// ****************************************
	sfhold_pkg::sfhold_phase_t phase;
	logic [7:0] sh;
	logic [3:0] cnt;
	logic [7:0] cmd;
	logic quad_in;
	logic quad_out;
	// starts at zero to match the cleared synchroniser on the system side
	logic toggle = 1'b0;
	logic [7:0] rx_byte;
	assign quad_in = (phase == sfhold_pkg::SFH_QIN);
	assign quad_out = (phase == sfhold_pkg::SFH_QOUT);

	// ****************************************
	// hold latch
	// ****************************************
	// hold starts/ends only while sck low: a level latch open while sck low
	// in quad phases the hold pin carries io3, so it never pauses there
	logic hold_act;
	always_latch begin
		if (cs_b_in) begin
			hold_act = 1'b0;
		end else if (!sck_in) begin
			hold_act = !hold_b_in && !quad_in && !quad_out;
		end
	end
	assign xf.held = hold_act;

	function automatic logic [3:0] step(input logic q);
		step = q ? sfhold_pkg::QUAD_NIBBLE : sfhold_pkg::SINGLE_BIT;
	endfunction

	logic [3:0] next_cnt;
	logic [7:0] next_sh;
	always_comb begin
		next_cnt = cnt + step(quad_in);
		next_sh = quad_in ? {sh[3:0], io_in} : {sh[6:0], io_in[0]};
	end

	// cs high acts as reset of transfer state
	always_ff @(posedge sck_in or posedge cs_b_in) begin
		if (cs_b_in) begin
			phase <= sfhold_pkg::SFH_IDLE;
			cnt <= '0;
			sh <= '0;
			cmd <= '0;
		end else if (!hold_act && !quad_out) begin
			sh <= next_sh;
			if (next_cnt == sfhold_pkg::BITS_PER_BYTE) begin
				cnt <= '0;
				if (phase == sfhold_pkg::SFH_IDLE) begin
					cmd <= next_sh;
					if (next_sh == sfhold_pkg::CMD_PROG_QUAD) begin
						phase <= sfhold_pkg::SFH_QIN;
					end else if (next_sh == sfhold_pkg::CMD_READ_QUAD) begin
						phase <= sfhold_pkg::SFH_QOUT;
					end else begin
						phase <= sfhold_pkg::SFH_CMD;
					end
				end
			end else begin
				cnt <= next_cnt;
			end
		end
	end

	// byte event toggles stay across frames so the system side sees each one
	always_ff @(posedge sck_in) begin
		if (!cs_b_in && !hold_act && !quad_out && next_cnt == sfhold_pkg::BITS_PER_BYTE) begin
			toggle <= !toggle;
			rx_byte <= next_sh;
		end
	end
	assign xf.rx_toggle = toggle;
	assign xf.rx_byte = rx_byte;
	assign xf.cmd = cmd;

	// ****************************************
	// quad output (falling edge)
	// ****************************************
	logic [3:0] onib;
	logic nsel;
	always_ff @(negedge sck_in or posedge cs_b_in) begin
		if (cs_b_in) begin
			nsel <= 1'b0;
			onib <= '0;
		end else if (!hold_act && quad_out) begin
			onib <= nsel ? xf.tx_byte[3:0] : xf.tx_byte[7:4];
			nsel <= !nsel;
		end
	end
	assign io_out = onib;
	// released while deselected or held; io3 input during quad program
	assign io_oe_out = (!cs_b_in && !hold_act && quad_out) ? 4'hf : 4'h0;
endmodule
`default_nettype wire

// >>> logic/sfhold_top.sv
// sfhold_top: serial flash hold and io3 control, system-side wrapper
`timescale 1ns/1ps
`default_nettype none
// How it works
// - hold active freezes shifting; clock and input ignored, no deselect.
// - during hold all data outputs are released.
// - hold never disturbs a running internal program or erase.
// - quad program takes four bits per rising edge, hold pin is io3.
// - quad read drives io3..io0 with four bits each falling edge.
// - after hold, shifting resumes at the same bit position.
// - inputs sampled on rising edges, outputs shifted on falling edges.
// - chip select high releases outputs and ignores input.
module sfhold_top (
	input wire logic SYS_CLK_IN,
	input wire logic RST_B_IN,
	input wire logic SCK_IN,
	input wire logic CS_B_IN,
	input wire logic HOLD_B_IN,
	input wire logic [3:0] IO_IN,
	output logic [3:0] IO_OUT,
	output logic [3:0] IO_OE_OUT,
	input wire logic BUSY_IN,
	input wire logic [7:0] TX_BYTE_IN,
	output logic [7:0] RX_BYTE_OUT,
	output logic RX_VALID_OUT,
	output logic [7:0] CMD_OUT,
	output logic HELD_OUT,
	output logic BUSY_OUT
);
	sfhold_xfer_if xf ();

	sfhold_link u_link (
		.sck_in(SCK_IN),
		.cs_b_in(CS_B_IN),
		.hold_b_in(HOLD_B_IN),
		.io_in(IO_IN),
		.io_out(IO_OUT),
		.io_oe_out(IO_OE_OUT),
		.xf(xf.link)
	);
	assign xf.tx_byte = TX_BYTE_IN;

	// ****************************************
	// crossing into system clock
	// ****************************************
	logic [2:0] tog_sync;
	logic [1:0] held_sync;
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			tog_sync <= '0;
			held_sync <= '0;
		end else begin
			tog_sync <= {tog_sync[1:0], xf.rx_toggle};
			held_sync <= {held_sync[0], xf.held};
		end
	end

	// byte stays stable a full byte time after its toggle
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			RX_VALID_OUT <= 1'b0;
			RX_BYTE_OUT <= '0;
			CMD_OUT <= '0;
		end else begin
			RX_VALID_OUT <= tog_sync[2] ^ tog_sync[1];
			if (tog_sync[2] ^ tog_sync[1]) begin
				RX_BYTE_OUT <= xf.rx_byte;
				CMD_OUT <= xf.cmd;
			end
		end
	end

	// internal busy is never gated by hold
	logic [1:0] busy_q;
	always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			busy_q <= '0;
		end else begin
			busy_q <= {busy_q[0], BUSY_IN};
		end
	end
	assign BUSY_OUT = busy_q[1];
	assign HELD_OUT = held_sync[1];
endmodule
`default_nettype wire

// >>> verification/sfhold_checker.sv
// sfhold_checker: port-level assertions for the hold and io3 control block
`timescale 1ns/1ps
`default_nettype none
module sfhold_checker (
	input wire logic SYS_CLK_IN,
	input wire logic RST_B_IN,
	input wire logic CS_B_IN,
	input wire logic HOLD_B_IN,
	input wire logic [3:0] IO_OE_OUT,
	input wire logic BUSY_IN,
	input wire logic [7:0] RX_BYTE_OUT,
	input wire logic RX_VALID_OUT,
	input wire logic HELD_OUT,
	input wire logic BUSY_OUT
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	oe_hold_a: assert property (!HOLD_B_IN && $past(!HOLD_B_IN) |-> IO_OE_OUT == 4'h0)
		else $error("outputs driven in hold");
	oe_desel_a: assert property (CS_B_IN && $past(CS_B_IN) |-> IO_OE_OUT == 4'h0)
		else $error("outputs driven while deselected");
	busy_copy_a: assert property (BUSY_IN |-> ##[1:3] BUSY_OUT)
		else $error("busy not passed");
	held_set_a: assert property (!HOLD_B_IN [*4] |-> HELD_OUT)
		else $error("hold not seen");
	held_clr_a: assert property (HOLD_B_IN [*4] |-> !HELD_OUT)
		else $error("hold not ended");
	valid_pulse_a: assert property (RX_VALID_OUT |=> !RX_VALID_OUT)
		else $error("valid longer than one cycle");
	rx_frozen_a: assert property (HELD_OUT [*6] |-> !RX_VALID_OUT)
		else $error("byte received in hold");
	quad_oe_a: assert property (RX_VALID_OUT && RX_BYTE_OUT == sfhold_pkg::CMD_READ_QUAD
		&& HOLD_B_IN |-> ##[0:4] IO_OE_OUT == 4'hf) else $error("quad read not driven");
endmodule
bind sfhold_top sfhold_checker chk_i (.*);
`default_nettype wire

// >>> verification/sfhold_host.sv
// sfhold_host: host controller model on the link side
`timescale 1ns/1ps
`default_nettype none
module sfhold_host (
	input wire logic [3:0] io_in,
	output logic sck_out,
	output logic cs_b_out,
	output logic hold_b_out,
	output logic [3:0] io_out
);
	logic [7:0] got;
	initial begin
		{sck_out, cs_b_out, hold_b_out, io_out} = 7'h1f;
		// clean rising edge of chip select clears the link state
		#1 cs_b_out = 1;
	end
	task automatic clk(input logic [3:0] v);
		io_out = v;
		#16 sck_out = 1;
		got = {got[3:0], io_in};
		#16 sck_out = 0;
	endtask
	task automatic pause();
		#4 hold_b_out = 0;
		clk(4'ha);
		#4 hold_b_out = 1;
	endtask
	task automatic send(input logic [7:0] d, input bit q, input int p);
		for (int i = q ? 1 : 7; i >= 0; i--) begin
			if (i == p) pause();
			clk(q ? d[i*4+:4] : {3'h0, d[i]});
		end
	endtask
endmodule
`default_nettype wire

// >>> verification/sfhold_tb_top.sv
// sfhold_tb_top: self-checking bench for the hold and io3 control block
`timescale 1ns/1ps
`default_nettype none
module sfhold_tb_top;
	logic clk, rst_b, busy, sck, cs_b, hold_b, rxv, held, busy_o;
	logic [3:0] hio, io_o, oe;
	logic [7:0] txb, rxb, cmd;
	int mismatches, total_checks, cyc;
	wire logic [3:0] pin = (oe & io_o) | (~oe & hio);
	sfhold_host host (.io_in(pin), .sck_out(sck), .cs_b_out(cs_b), .hold_b_out(hold_b),
		.io_out(hio));
	sfhold_top uut (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .SCK_IN(sck), .CS_B_IN(cs_b),
		.HOLD_B_IN(hold_b), .IO_IN(pin), .IO_OUT(io_o), .IO_OE_OUT(oe), .BUSY_IN(busy),
		.TX_BYTE_IN(txb), .RX_BYTE_OUT(rxb), .RX_VALID_OUT(rxv), .CMD_OUT(cmd),
		.HELD_OUT(held), .BUSY_OUT(busy_o));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic t_hold();
		host.cs_b_out = 0;
		host.send(8'h5a, 0, 3);
		repeat (6) @(posedge clk);
		chk(rxb, 8'h5a);
		host.cs_b_out = 1;
		$display("hold test done");
	endtask
	task automatic t_quad_in();
		repeat (2) @(posedge clk);
		host.cs_b_out = 0;
		host.send(sfhold_pkg::CMD_PROG_QUAD, 0, 9);
		host.send(8'hc3, 1, 9);
		repeat (6) @(posedge clk);
		chk(cmd, sfhold_pkg::CMD_PROG_QUAD);
		chk(rxb, 8'hc3);
		host.cs_b_out = 1;
		host.send(8'h3c, 0, 9);
		repeat (6) @(posedge clk);
		chk(rxb, 8'hc3);
		$display("quad program test done");
	endtask
	task automatic t_quad_out();
		@(posedge clk);
		txb <= 8'h96;
		host.cs_b_out = 0;
		host.send(sfhold_pkg::CMD_READ_QUAD, 0, 9);
		host.send(8'h00, 1, 9);
		chk(host.got, 8'h96);
		chk({4'h0, oe}, 8'h0f);
		host.cs_b_out = 1;
		$display("quad read test done");
	endtask
	task automatic t_busy();
		repeat (2) @(posedge clk);
		host.cs_b_out = 0;
		#4 host.hold_b_out = 0;
		@(posedge clk);
		busy <= 1;
		repeat (4) @(posedge clk);
		chk({7'h0, busy_o}, 8'h01);
		chk({7'h0, held}, 8'h01);
		busy <= 0;
		host.hold_b_out = 1;
		host.cs_b_out = 1;
		$display("busy test done");
	endtask
	initial begin
		rst_b = 0;
		busy = 0;
		txb = 8'h00;
		repeat (10) @(posedge clk);
		rst_b <= 1;
		repeat (4) @(posedge clk);
		t_hold();
		t_quad_in();
		t_quad_out();
		t_busy();
		final_report();
	end
endmodule
`default_nettype wire
